// file: include/spiss_consts.svh
// Constants of the serial target port: register offsets, fields, reset values.
// Assumes an 8-bit register port with 16-bit addresses.
//
// What this block does
// - Keep the last 8-bit command byte from the master, read-only for the processor.
// - Port works on its pins only while enabled (reset 1) and pin map is zero.
// - Restricted mode: host writes only to command byte and a 16 byte window.
// - Status byte shows the last finished transaction, read-only, resets to zero.
// - Status bit 7 flags a read or write not done because not ready.
// - Status bit 6 is parity of bytes sent, status byte excluded.
// - Status bit 5 is parity of all received bytes, command and address included.
// - Status bits 4:2 are low three bits of data byte count.
// - Transactions of one to three bytes report count field 111.
// - Status bit 1 shows flash mode, zero while test pin is low.
// - Status bit 0 shows flash ready for another write, in flash mode.
// - Protect bit refuses external flash reads through the serial port.
// - Protect bit blocks erase of page 0 and engine code area.
`ifndef SPISS_CONSTS_SVH
`define SPISS_CONSTS_SVH

`define SPISS_ADR_PROTECT   16'h00b2
`define SPISS_ADR_CMD       16'h00fd
`define SPISS_ADR_STATUS    16'h2708
`define SPISS_ADR_CTRL      16'h270c
`define SPISS_ADR_IRQ_STAT  16'h2710
`define SPISS_ADR_IRQ_MASK  16'h2714
`define SPISS_ADR_WIN_LO    16'h2718
`define SPISS_ADR_WIN_HI    16'h2719
`define SPISS_ADR_FMODE     16'h271a

`define SPISS_BIT_PROTECT   6
`define SPISS_BIT_ENABLE    4
`define SPISS_BIT_SAFE      3
`define SPISS_RST_ENABLE    1'b1
`define SPISS_RST_SAFE      1'b0
`define SPISS_RST_PROTECT   1'b0
`define SPISS_RST_STATUS    6'h00

`define SPISS_CMD_ERASE     8'h20
`define SPISS_BIT_RD_CMD    7
`define SPISS_HDR_BYTES     8'h03
`define SPISS_WIN_SIZE      16'h0010
`define SPISS_CNT_SHORT     3'h7

`endif

// file: include/spiss_pkg.sv
// Types of the serial target port.
// Assumes the constants header is included alongside.
package spiss_pkg;

   typedef struct packed {
      logic       sclk_s1, sclk_s2, sclk_d;
      logic       cs_s1, cs_s2, cs_d;
      logic       mosi_s1, mosi_s2;
      logic       test_s1, test_s2;
      logic       busy;
      logic [2:0] bit_cnt;
      logic [7:0] byte_cnt;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic [7:0] tx_next;
      logic [7:0] cmd;
      logic [15:0] addr;
      logic       rpar, wpar, nrdy, rd_pend;
      logic [5:0] status;
      logic       prot, safe, en, fmode;
      logic [15:0] win_base;
      logic [2:0] irq_st, irq_mask;
      logic [7:0] rdata;
      logic       oe_n;
      logic       mem_we, mem_re, erase;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
   } spiss_state_type;

endpackage

// file: verilog/spiss_port.sv
// Serial target port: link front end, status byte, register file, interrupts.
// Assumes link pins are asynchronous; memory and register ports on clk_in.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "spiss_consts.svh"

module spiss_port
   import spiss_pkg::*;
#(
   parameter logic [15:0] FLASH_BASE = 16'h8000,
   parameter logic [15:0] PAGE_SIZE  = 16'h0400
) (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             irq_out,
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        mosi_in,
   output logic             miso_out,
   output logic             miso_oe_n_out,
   input  wire logic        test_pin_in,
   input  wire logic [3:0]  segment_pin_map_in,
   input  wire logic [15:0] engine_code_location_in,
   input  wire logic        flash_ready_in,
   output logic      [15:0] mem_addr_out,
   output logic      [7:0]  mem_wdata_out,
   output logic             mem_we_out,
   output logic             mem_re_out,
   input  wire logic [7:0]  mem_rdata_in,
   input  wire logic        mem_ready_in,
   output logic             flash_erase_out
);

   spiss_state_type r, n;

   logic        link_on;
   logic        sclk_rise, sclk_fall, cs_start, cs_end;
   logic        byte_done, cmd_done, is_read, fetch, fetch_blk;
   logic        wr_try, wr_ok, er_try, er_blk;
   logic [7:0]  rx_byte;
   logic [15:0] fetch_addr;
   logic [7:0]  status_live;
   logic [2:0]  ev;
   logic [2:0]  irq_clr;

   // Odd number of ones gives 1
   function automatic logic par8(input logic [7:0] b);
      par8 = ^b;
   endfunction

   function automatic logic in_win(input logic [15:0] a, input logic [15:0] base);
      in_win = (a >= base) && ((a - base) < `SPISS_WIN_SIZE);
   endfunction

   // Bits 1:0 are live so the processor can poll flash readiness
   assign status_live = {r.status, r.fmode & r.test_s2,
                         r.fmode & r.test_s2 & flash_ready_in};
   assign link_on     = r.en && (segment_pin_map_in == 4'h0);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n          = r;
      ev         = 3'h0;
      irq_clr    = 3'h0;
      n.mem_we   = 1'b0;
      n.mem_re   = 1'b0;
      n.erase    = 1'b0;
      n.rd_pend  = 1'b0;
      fetch      = 1'b0;
      fetch_blk  = 1'b0;
      fetch_addr = r.addr;
      wr_try     = 1'b0;
      wr_ok      = 1'b0;
      er_try     = 1'b0;
      er_blk     = 1'b0;

      // Two-stage synchronisers; only stage two is looked at
      n.sclk_s1 = sclk_in;
      n.sclk_s2 = r.sclk_s1;
      n.sclk_d  = r.sclk_s2;
      n.cs_s1   = cs_n_in;
      n.cs_s2   = r.cs_s1;
      n.cs_d    = r.cs_s2;
      n.mosi_s1 = mosi_in;
      n.mosi_s2 = r.mosi_s1;
      n.test_s1 = test_pin_in;
      n.test_s2 = r.test_s1;

      sclk_rise = r.busy && r.sclk_s2 && !r.sclk_d;
      sclk_fall = r.busy && !r.sclk_s2 && r.sclk_d;
      cs_start  = link_on && !r.busy && !r.cs_s2 && r.cs_d;
      cs_end    = r.busy && r.cs_s2;
      rx_byte   = {r.rx_sh[6:0], r.mosi_s2};
      byte_done = sclk_rise && (r.bit_cnt == 3'h7);
      cmd_done  = byte_done && (r.byte_cnt == 8'h00);
      is_read   = r.cmd[`SPISS_BIT_RD_CMD];

      if (cs_start) begin
         n.busy     = 1'b1;
         n.bit_cnt  = 3'h0;
         n.byte_cnt = 8'h00;
         n.rpar     = 1'b0;
         n.wpar     = 1'b0;
         n.nrdy     = 1'b0;
         n.tx_sh    = 8'h00;
         n.tx_next  = 8'h00;
      end

      if (sclk_rise) begin
         n.rx_sh   = rx_byte;
         n.bit_cnt = r.bit_cnt + 3'h1;
      end

      if (byte_done) begin
         n.wpar = r.wpar ^ par8(rx_byte);
         // Count a sent byte once all its bits went out, never a byte only loaded
         if (is_read && r.byte_cnt >= `SPISS_HDR_BYTES)
            n.rpar = r.rpar ^ par8(r.tx_next);
         if (r.byte_cnt != 8'hff)
            n.byte_cnt = r.byte_cnt + 8'h01;
         case (r.byte_cnt)
            8'h00: begin
               n.cmd = rx_byte;
               ev[0] = 1'b1;
            end
            8'h01: n.addr[15:8] = rx_byte;
            8'h02: begin
               n.addr[7:0] = rx_byte;
               fetch_addr  = {r.addr[15:8], rx_byte};
               fetch       = is_read;
            end
            default: begin
               if (is_read) begin
                  fetch = 1'b1;
               end else if (r.cmd != `SPISS_CMD_ERASE) begin
                  wr_try = 1'b1;
                  n.addr = r.addr + 16'h0001;
                  // Command byte is always taken; data only inside the window
                  if (r.safe && !in_win(r.addr, r.win_base)) begin
                     ev[2] = 1'b1;
                  end else if (!mem_ready_in) begin
                     n.nrdy = 1'b1;
                  end else begin
                     wr_ok       = 1'b1;
                     n.mem_we    = 1'b1;
                     n.mem_addr  = r.addr;
                     n.mem_wdata = rx_byte;
                  end
               end
            end
         endcase
      end

      // Read prefetch: data must be ready before the next falling edge
      if (fetch) begin
         n.addr = fetch_addr + 16'h0001;
         if (r.prot && (fetch_addr >= FLASH_BASE)) begin
            fetch_blk = 1'b1;
            n.tx_next = 8'h00;
            ev[2]     = 1'b1;
         end else begin
            n.mem_re   = 1'b1;
            n.mem_addr = fetch_addr;
            n.rd_pend  = 1'b1;
         end
      end
      if (r.rd_pend) begin
         n.tx_next = mem_rdata_in;
         if (!mem_ready_in)
            n.nrdy = 1'b1;
      end

      if (sclk_fall) begin
         if (r.bit_cnt == 3'h0 && r.byte_cnt >= `SPISS_HDR_BYTES && is_read) begin
            n.tx_sh = r.tx_next;
         end else begin
            n.tx_sh = {r.tx_sh[6:0], 1'b0};
         end
      end

      // End of transaction: whole status in one step
      if (cs_end) begin
         n.busy   = 1'b0;
         n.status = {r.nrdy, r.rpar, r.wpar,
                     (r.byte_cnt <= `SPISS_HDR_BYTES) ? `SPISS_CNT_SHORT :
                     3'(r.byte_cnt - `SPISS_HDR_BYTES)};
         ev[1]    = 1'b1;
         if (r.cmd == `SPISS_CMD_ERASE && r.byte_cnt >= `SPISS_HDR_BYTES
             && r.fmode && r.test_s2) begin
            er_try = 1'b1;
            er_blk = r.prot && (r.addr < PAGE_SIZE || r.addr >= engine_code_location_in);
            if (er_blk)
               ev[2] = 1'b1;
            else
               n.erase = 1'b1;
            n.mem_addr = r.addr;
         end
      end
      n.oe_n = !(n.busy && link_on);
      if (!link_on)
         n.busy = 1'b0;

      // -------------------------------------------------------------
      // Register port
      // -------------------------------------------------------------
      if (reg_wr_in) begin
         case (reg_addr_in)
            `SPISS_ADR_PROTECT:  n.prot = reg_wdata_in[`SPISS_BIT_PROTECT];
            `SPISS_ADR_CTRL: begin
               n.en   = reg_wdata_in[`SPISS_BIT_ENABLE];
               n.safe = reg_wdata_in[`SPISS_BIT_SAFE];
            end
            `SPISS_ADR_IRQ_STAT: irq_clr = reg_wdata_in[2:0];
            `SPISS_ADR_IRQ_MASK: n.irq_mask = reg_wdata_in[2:0];
            `SPISS_ADR_WIN_LO:   n.win_base[7:0] = reg_wdata_in;
            `SPISS_ADR_WIN_HI:   n.win_base[15:8] = reg_wdata_in;
            `SPISS_ADR_FMODE:    n.fmode = reg_wdata_in[0];
            default: ;
         endcase
      end
      // A new event beats a clear in the same cycle
      n.irq_st = (r.irq_st & ~irq_clr) | ev;

      n.rdata = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `SPISS_ADR_PROTECT:  n.rdata = {1'b0, r.prot, 6'h00};
            `SPISS_ADR_CMD:      n.rdata = r.cmd;
            `SPISS_ADR_STATUS:   n.rdata = status_live;
            `SPISS_ADR_CTRL:     n.rdata = {3'h0, r.en, r.safe, 3'h0};
            `SPISS_ADR_IRQ_STAT: n.rdata = {5'h00, r.irq_st};
            `SPISS_ADR_IRQ_MASK: n.rdata = {5'h00, r.irq_mask};
            `SPISS_ADR_WIN_LO:   n.rdata = r.win_base[7:0];
            `SPISS_ADR_WIN_HI:   n.rdata = r.win_base[15:8];
            `SPISS_ADR_FMODE:    n.rdata = {7'h00, r.fmode};
            default:             n.rdata = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r        <= '0;
         r.sclk_s1 <= 1'b0;
         r.cs_s1  <= 1'b1;
         r.cs_s2  <= 1'b1;
         r.cs_d   <= 1'b1;
         r.oe_n   <= 1'b1;
         r.en     <= `SPISS_RST_ENABLE;
         r.safe   <= `SPISS_RST_SAFE;
         r.prot   <= `SPISS_RST_PROTECT;
         r.status <= `SPISS_RST_STATUS;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata_out   = r.rdata;
   assign irq_out         = |(r.irq_st & r.irq_mask);
   assign miso_out        = r.tx_sh[7];
   assign miso_oe_n_out   = r.oe_n;
   assign mem_addr_out    = r.mem_addr;
   assign mem_wdata_out   = r.mem_wdata;
   assign mem_we_out      = r.mem_we;
   assign mem_re_out      = r.mem_re;
   assign flash_erase_out = r.erase;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_end;
      cs_end;
   endsequence
   sequence s_short_end;
      cs_end && (r.byte_cnt <= `SPISS_HDR_BYTES);
   endsequence

   property p_cmd_capture;
      cmd_done |=> (r.cmd == $past(rx_byte));
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command byte not kept");

   property p_link_off;
      !link_on |=> miso_oe_n_out && !r.busy;
   endproperty
   a_link_off: assert property (p_link_off) else $error("port drives while disabled");

   property p_safe_reject;
      (wr_try && r.safe && !in_win(r.addr, r.win_base)) |=> !mem_we_out;
   endproperty
   a_safe_reject: assert property (p_safe_reject) else $error("write outside window taken");

   property p_status_hold;
      (r.busy && !cs_end) |=> $stable(r.status);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status moved mid transaction");

   sequence s_wr_stall;
      wr_try && !(r.safe && !in_win(r.addr, r.win_base)) && !mem_ready_in;
   endsequence
   property p_not_ready;
      s_wr_stall |=> r.nrdy && !mem_we_out;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("stalled write not flagged");

   property p_nrdy_flag;
      (r.rd_pend && !mem_ready_in && r.busy && !cs_end) |=> r.nrdy;
   endproperty
   a_nrdy_flag: assert property (p_nrdy_flag) else $error("not ready not flagged");

   property p_parity_out;
      s_end |=> (r.status[4] == $past(r.rpar)) && (r.status[3] == $past(r.wpar));
   endproperty
   a_parity_out: assert property (p_parity_out) else $error("parity bits wrong");

   property p_count_short;
      s_short_end |=> (r.status[2:0] == `SPISS_CNT_SHORT) ##1 $stable(r.status[2:0]) || cs_end;
   endproperty
   a_count_short: assert property (p_count_short) else $error("short count not 111");

   property p_count_long;
      (s_end and (r.byte_cnt == 8'h05)) |=> (r.status[2:0] == 3'h2);
   endproperty
   a_count_long: assert property (p_count_long) else $error("data byte count wrong");

   property p_fmode_test;
      !r.test_s2 |-> (status_live[1:0] == 2'h0);
   endproperty
   a_fmode_test: assert property (p_fmode_test) else $error("flash mode shown with test low");

   property p_protect_read;
      (fetch && r.prot && fetch_addr >= FLASH_BASE) |=> !mem_re_out ##1 (r.tx_next == 8'h00);
   endproperty
   a_protect_read: assert property (p_protect_read) else $error("protected flash read");

   property p_erase_block;
      (er_try && er_blk) |=> !flash_erase_out && r.irq_st[2];
   endproperty
   a_erase_block: assert property (p_erase_block) else $error("protected erase issued");

   property p_erase_pulse;
      flash_erase_out |=> !flash_erase_out;
   endproperty
   a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse too long");

   property p_status_ro;
      (reg_wr_in && (reg_addr_in == `SPISS_ADR_STATUS) && !cs_end) |=> $stable(r.status);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status written by processor");

   property p_cmd_ro;
      (reg_wr_in && (reg_addr_in == `SPISS_ADR_CMD) && !cmd_done) |=> $stable(r.cmd);
   endproperty
   a_cmd_ro: assert property (p_cmd_ro) else $error("command byte written by processor");

   sequence s_sent_byte;
      byte_done && is_read && (r.byte_cnt >= `SPISS_HDR_BYTES);
   endsequence
   property p_tx_parity;
      s_sent_byte |=> (r.rpar == ($past(r.rpar) ^ (^$past(r.tx_next))));
   endproperty
   a_tx_parity: assert property (p_tx_parity) else $error("sent byte parity not folded in");

   // Read data stands one cycle only
   property p_rdata_idle;
      !reg_rd_in |=> (reg_rdata_out == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

endmodule // spiss_port

// file: verification/spiss_master.sv
// Link master model: drives frames of whole bytes, mode 0, MSB first.
// Assumes the caller leaves the target idle for at least 3 clocks after reset.
`timescale 1ns/1ps

module spiss_master (
   input  wire logic miso_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out
);
   // Clock stands low between frames; data line shows the inverse when idle
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
   end

   // ---------------------------------------------------------------
   // Frame of n bytes, byte i in tx[63-8*i -: 8]
   // ---------------------------------------------------------------
   task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
      int i;
      rx = 64'h0;
      // Odd offset keeps the link phase unrelated to the system clock
      #13.7;
      cs_n_out = 1'b0;
      for (i = 0; i < 8 * n; i++) begin
         mosi_out = tx[63 - i];
         #24 sclk_out = 1'b1;
         rx[63 - i] = miso_in;
         #24 sclk_out = 1'b0;
      end
      #24 cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
      // Idle gap well above 4 clocks, status settles meanwhile
      #60;
   endtask
endmodule // spiss_master

// file: verification/testbench.sv
// Testbench of the serial target port: register tasks, link frames, memory stub.
// Assumes the link master model and design defaults FLASH_BASE 0x8000, PAGE_SIZE 0x0400.
`timescale 1ns/1ps
`include "spiss_consts.svh"

module testbench;
   logic        clk_in             = 1'b0;
   logic        reset_n_in         = 1'b0;
   logic [15:0] reg_addr_in        = 16'h0000;
   logic [7:0]  reg_wdata_in       = 8'h00;
   logic        reg_wr_in          = 1'b0;
   logic        reg_rd_in          = 1'b0;
   logic        test_pin_in        = 1'b0;
   logic [3:0]  segment_pin_map_in = 4'h0;
   logic        flash_ready_in     = 1'b0;
   logic        mem_ready_in       = 1'b1;
   logic [7:0]  mem_rdata_in;
   logic [7:0]  junk_q             = 8'h00;
   logic [7:0]  reg_rdata_out, mem_wdata_out, we_data, rd_v;
   logic [15:0] mem_addr_out, we_addr;
   logic        irq_out, sclk, cs_n, mosi, miso_out, miso_oe_n_out, mem_we_out, mem_re_out, flash_erase_out;
   logic [63:0] rx, tx;
   logic [15:0] ea [5] = '{16'h0000, 16'h0400, 16'hbfff, 16'hc000, 16'h0000};
   int          eexp [5] = '{0, 1, 1, 0, 1};
   int          err_total = 0;
   int          cmp_count = 0;
   int          we_cnt = 0, re_cnt = 0, er_cnt = 0, oe_cnt = 0, n0, c0, c1;

   always #2.5 clk_in = ~clk_in;

   spiss_port u_spiss_port (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .irq_out(irq_out), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso_out),
      .miso_oe_n_out(miso_oe_n_out), .test_pin_in(test_pin_in), .segment_pin_map_in(segment_pin_map_in),
      .engine_code_location_in(16'hc000), .flash_ready_in(flash_ready_in), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
      .mem_rdata_in(mem_rdata_in), .mem_ready_in(mem_ready_in), .flash_erase_out(flash_erase_out));

   // Released data line shows the inverse of the last bit
   spiss_master u_spiss_master (.miso_in(miso_oe_n_out ? ~miso_out : miso_out), .sclk_out(sclk), .cs_n_out(cs_n),
      .mosi_out(mosi));

   // ---------------------------------------------------------------
   // Memory stub and pulse monitor
   // ---------------------------------------------------------------
   // Read data valid only while the strobe stands, scrambled otherwise
   always_comb mem_rdata_in = (mem_re_out === 1'b1) ? (mem_addr_out[7:0] ^ 8'h5a) : junk_q;
   always @(posedge clk_in) begin
      junk_q <= ~junk_q;
      if (mem_we_out === 1'b1) begin
         we_cnt++;
         we_addr <= mem_addr_out;
         we_data <= mem_wdata_out;
      end
      if (mem_re_out === 1'b1) re_cnt++;
      if (flash_erase_out === 1'b1) er_cnt++;
      if (miso_oe_n_out === 1'b0) oe_cnt++;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      #1 d = reg_rdata_out;
   endtask

   task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
      reg_rd(a, rd_v);
      chk(what, {8'h00, exp}, {8'h00, rd_v});
   endtask

   task automatic frm(input int n, input logic [63:0] t);
      u_spiss_master.frame(n, t, rx);
   endtask

   // Status byte expected with flash mode off
   function automatic logic [7:0] st(input logic nr, input logic rp, input logic [63:0] t, input int tot);
      return {nr, rp, ^t, (tot <= 3) ? 3'h7 : 3'(tot - 3), 2'b00};
   endfunction

   task automatic end_sim;
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      #200000;
      err_total++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rchk("status_rst", `SPISS_ADR_STATUS, 8'h00);
      rchk("ctrl_rst", `SPISS_ADR_CTRL, 8'h10);
      rchk("protect_rst", `SPISS_ADR_PROTECT, 8'h00);
      rchk("unmapped", 16'h1234, 8'h00);
      reg_wr(`SPISS_ADR_STATUS, 8'hff);
      rchk("status_ro", `SPISS_ADR_STATUS, 8'h00);
      tx = 64'h010010a5_00000000;
      frm(4, tx);
      chk("we_cnt", 1, we_cnt);
      chk("we_addr", 16'h0010, we_addr);
      chk("we_data", 8'ha5, we_data);
      chk("oe_active", 1, oe_cnt > 0);
      rchk("status_wr", `SPISS_ADR_STATUS, st(0, 0, tx, 4));
      rchk("cmd", `SPISS_ADR_CMD, 8'h01);
      reg_wr(`SPISS_ADR_CMD, 8'hee);
      rchk("cmd_ro", `SPISS_ADR_CMD, 8'h01);
      for (n0 = 1; n0 <= 3; n0++) begin
         tx = 64'h01020300_00000000 & ~(64'hffffffff_ffffffff >> (8 * n0));
         frm(n0, tx);
         rchk("status_short", `SPISS_ADR_STATUS, st(0, 0, tx, n0));
      end
      tx = 64'h80010000_00000000;
      frm(5, tx);
      chk("rd_byte0", 8'h5a, rx[39:32]);
      chk("rd_byte1", 8'h5b, rx[31:24]);
      rchk("status_rd", `SPISS_ADR_STATUS, st(0, ^16'h5a5b, tx, 5));
      // Memory not ready during a write, then during a read
      @(posedge clk_in) mem_ready_in <= 1'b0;
      for (n0 = 0; n0 < 2; n0++) begin
         tx = (n0 == 0) ? 64'h01003077_00000000 : 64'h80003000_00000000;
         frm(4, tx);
         rchk("status_nrdy", `SPISS_ADR_STATUS, st(1, (n0 == 0) ? 1'b0 : ^8'h6a, tx, 4));
      end
      @(posedge clk_in) mem_ready_in <= 1'b1;
      // Protected flash read at the flash base
      reg_wr(`SPISS_ADR_PROTECT, 8'h40);
      c0 = re_cnt;
      tx = 64'h80800000_00000000;
      frm(4, tx);
      chk("prot_rd_data", 8'h00, rx[39:32]);
      chk("prot_rd_re", c0, re_cnt);
      rchk("status_prot", `SPISS_ADR_STATUS, st(0, 0, tx, 4));
      // Flash mode, erase boundaries with and without protection
      reg_wr(`SPISS_ADR_FMODE, 8'h01);
      @(posedge clk_in);
      test_pin_in    <= 1'b1;
      flash_ready_in <= 1'b1;
      // Test pin crosses two flip-flops first
      repeat (2) @(posedge clk_in);
      for (n0 = 0; n0 < 5; n0++) begin
         if (n0 == 4) reg_wr(`SPISS_ADR_PROTECT, 8'h00);
         reg_rd(`SPISS_ADR_STATUS, rd_v);
         chk("flash_ready", 2'b11, rd_v[1:0]);
         tx = {8'h20, ea[n0], 40'h0};
         c0 = er_cnt;
         frm(3, tx);
         chk("erase", eexp[n0], er_cnt - c0);
      end
      @(posedge clk_in) flash_ready_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      reg_rd(`SPISS_ADR_STATUS, rd_v);
      chk("flash_busy", 2'b10, rd_v[1:0]);
      @(posedge clk_in) test_pin_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      reg_rd(`SPISS_ADR_STATUS, rd_v);
      chk("test_low", 2'b00, rd_v[1:0]);
      reg_wr(`SPISS_ADR_FMODE, 8'h00);
      // Restricted writes: last window byte kept, one past it dropped
      reg_wr(`SPISS_ADR_CTRL, 8'h18);
      reg_wr(`SPISS_ADR_WIN_LO, 8'h00);
      reg_wr(`SPISS_ADR_WIN_HI, 8'h02);
      reg_wr(`SPISS_ADR_IRQ_STAT, 8'h07);
      frm(4, 64'h01020f33_00000000);
      chk("win_last", 16'h020f, we_addr);
      c0 = we_cnt;
      frm(4, 64'h01021044_00000000);
      chk("win_out", c0, we_cnt);
      rchk("irq_stat", `SPISS_ADR_IRQ_STAT, 8'h07);
      chk("irq_masked", 0, irq_out);
      reg_wr(`SPISS_ADR_IRQ_MASK, 8'h04);
      chk("irq_raised", 1, irq_out);
      reg_wr(`SPISS_ADR_IRQ_STAT, 8'h04);
      chk("irq_cleared", 0, irq_out);
      rchk("irq_stat_clr", `SPISS_ADR_IRQ_STAT, 8'h03);
      // Port disabled, then pin map in use: target stays off the pins
      for (n0 = 0; n0 < 2; n0++) begin
         reg_wr(`SPISS_ADR_CTRL, (n0 == 0) ? 8'h00 : 8'h10);
         @(posedge clk_in) segment_pin_map_in <= (n0 == 0) ? 4'h0 : 4'h8;
         c0 = oe_cnt;
         c1 = we_cnt;
         frm(4, 64'h01000166_00000000);
         chk("off_oe", c0, oe_cnt);
         chk("off_we", c1, we_cnt);
      end
      end_sim();
   end
endmodule // testbench
